/* File: design/fiao_info_rom.sv */
// Constant contents of the 128-byte information area.
// Assumes the caller registers the output; this table is combinational.
`timescale 1ns/1ns
module fiao_info_rom
   import fiao_pkg::*;
#(
   parameter logic [511:0] OPTION_BYTES = {64{8'hff}},
   parameter logic [159:0] PART_NUMBER = {"PART0001", {12{8'h0f}}}
) (
   input wire logic [6:0] index,
   output logic [7:0] data
);
   logic [6:0] pn_off;

   // There is no write path at all, so the contents cannot change.
   always_comb begin
      pn_off = index - FIAO_PN_FIRST;
      if (index < FIAO_PN_FIRST) begin
         data = OPTION_BYTES[511 - 8 * index -: 8];
      end else if (index <= FIAO_PN_LAST) begin
         data = PART_NUMBER[159 - 8 * pn_off -: 8];
      end else begin
         data = FIAO_RESERVED_FILL;
      end
   end
endmodule : fiao_info_rom

/* File: design/fiao_overlay.sv */
// Information-area overlay on the program memory read path.
// Assumes the core presents one read at a time and takes data a cycle later.
// Assumes program memory answers in the request cycle and that program
// requests carry their target on the read address.
// The overlay costs one mux level and a nine-bit compare in the read path.
//
// Behaviour
// - Overlay active only while page select bit 7 is 1.
// - The 128-byte area maps over program addresses FE00H to FE7FH.
// - While active, window reads return area bytes, not program memory.
// - The area is read-only; writes or programming never change it.
// - FE40-FE53 hold a 20-character left-justified part number padded with 0FH.
`timescale 1ns/1ns
module fiao_overlay
   import fiao_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic page_sel_wr,
   input wire logic [7:0] page_sel_wdata,
   output logic [7:0] page_sel_q,
   input wire logic rd_req,
   input wire logic [15:0] rd_addr,
   input wire logic [7:0] pmem_rdata,
   input wire logic prog_wr,
   output logic [7:0] rd_data_q,
   output logic rd_valid_q,
   output logic prog_wr_ok
);
   // ----------------------------------------------------------------
   // Select register and window decode
   // ----------------------------------------------------------------
   logic overlay_on;
   logic in_window;
   logic overlay_hit;
   logic [FIAO_IDX_W-1:0] area_idx;
   logic [7:0] info_byte;
   logic [7:0] rd_data_d;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         page_sel_q <= FIAO_PAGE_SEL_RESET;
      end else if (page_sel_wr) begin
         page_sel_q <= page_sel_wdata;
      end
   end

   assign overlay_on = page_sel_q[FIAO_SEL_BIT];
   assign in_window = (rd_addr[15:7] == FIAO_WIN_TAG);
   assign overlay_hit = overlay_on && in_window;
   assign area_idx = rd_addr[FIAO_IDX_W-1:0];

   fiao_info_rom u_rom (
      .index(area_idx),
      .data(info_byte)
   );

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Program memory data arrives in the request cycle; the mux result is
   // registered so both sources share the same one-cycle latency.
   always_comb begin
      if (overlay_hit) begin
         rd_data_d = info_byte;
      end else begin
         rd_data_d = pmem_rdata;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_q <= FIAO_RD_RESET;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_req;
         if (rd_req) begin
            rd_data_q <= rd_data_d;
         end
      end
   end

   // Writes into the window while the overlay is on are blocked from
   // reaching program flash, so neither store can be altered by them.
   assign prog_wr_ok = prog_wr && !overlay_hit;

   // ----------------------------------------------------------------
   // Checker helpers
   // ----------------------------------------------------------------
   // The span is worked out from the full window bounds instead of the
   // tag compare, so a slip in the decode shows up as a disagreement.
   logic chk_in_span;
   logic chk_in_pn;
   logic chk_in_rsv;
   logic chk_last_hit_q;
   logic [FIAO_IDX_W-1:0] chk_last_idx_q;
   logic chk_seen_q;
   logic [FIAO_IDX_W-1:0] chk_idx_q;
   logic [7:0] chk_byte_q;

   assign chk_in_span = (rd_addr >= FIAO_WIN_FIRST) && (rd_addr <= FIAO_WIN_LAST);
   assign chk_in_pn = chk_in_span && (area_idx >= FIAO_PN_FIRST)
      && (area_idx <= FIAO_PN_LAST);
   assign chk_in_rsv = chk_in_span && (area_idx > FIAO_PN_LAST);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         chk_last_hit_q <= 1'b0;
         chk_last_idx_q <= '0;
      end else if (rd_req) begin
         chk_last_hit_q <= overlay_on && chk_in_span;
         chk_last_idx_q <= area_idx;
      end
   end

   // Only the first byte read from the area is kept; any later read of
   // the same location must return it unchanged.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         chk_seen_q <= 1'b0;
         chk_idx_q <= '0;
         chk_byte_q <= FIAO_RD_RESET;
      end else if (rd_valid_q && chk_last_hit_q && !chk_seen_q) begin
         chk_seen_q <= 1'b1;
         chk_idx_q <= chk_last_idx_q;
         chk_byte_q <= rd_data_q;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_overlay_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && page_sel_q[7] && rd_addr >= FIAO_WIN_FIRST && rd_addr <= FIAO_WIN_LAST
      |=> rd_valid_q && rd_data_q == $past(info_byte))
      else $error("window read did not return area byte");

   a_plain_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && !page_sel_q[7] |=> rd_data_q == $past(pmem_rdata))
      else $error("overlay off but program data altered");

   a_outside_window: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && (rd_addr < FIAO_WIN_FIRST || rd_addr > FIAO_WIN_LAST)
      |=> rd_data_q == $past(pmem_rdata))
      else $error("read outside window was overlaid");

   a_sel_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
      page_sel_wr |=> overlay_on == $past(page_sel_wdata[7]))
      else $error("overlay enable did not follow select bit");

   a_write_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
      prog_wr && page_sel_q[FIAO_SEL_BIT] && chk_in_span |-> !prog_wr_ok)
      else $error("write reached overlaid area");

   a_pad_fill: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && overlay_on && rd_addr == 16'hfe53 |=> rd_data_q == FIAO_PN_FILL)
      else $error("part number tail not padded");

   a_valid_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !rd_req |=> !rd_valid_q)
      else $error("valid without request");

   // ----------------------------------------------------------------
   // Window decode checks
   // ----------------------------------------------------------------
   a_decode_agree: assert property (@(posedge clk_sys) disable iff (!reset_n)
      in_window == chk_in_span)
      else $error("window decode disagrees with bounds");

   a_edge_below: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && overlay_on && rd_addr == FIAO_WIN_FIRST - 16'h0001
      |=> rd_data_q == $past(pmem_rdata))
      else $error("address below window was overlaid");

   a_edge_above: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && overlay_on && rd_addr == FIAO_WIN_LAST + 16'h0001
      |=> rd_data_q == $past(pmem_rdata))
      else $error("address above window was overlaid");

   // ----------------------------------------------------------------
   // Select register checks
   // ----------------------------------------------------------------
   a_sel_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      page_sel_wr |=> page_sel_q == $past(page_sel_wdata))
      else $error("select register did not load");

   a_sel_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !page_sel_wr |=> $stable(page_sel_q))
      else $error("select register changed without a write");

   // ----------------------------------------------------------------
   // Read path checks
   // ----------------------------------------------------------------
   a_valid_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req |=> rd_valid_q)
      else $error("read request got no valid");

   a_data_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !rd_req |=> $stable(rd_data_q))
      else $error("read data changed without a request");

   a_reserved_fill: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && overlay_on && chk_in_rsv |=> rd_data_q == FIAO_RESERVED_FILL)
      else $error("reserved area byte not filled");

   a_area_stable: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && overlay_on && chk_in_span && chk_seen_q && area_idx == chk_idx_q
      |=> rd_data_q == chk_byte_q)
      else $error("area byte changed between reads");

   // ----------------------------------------------------------------
   // Part number checks
   // ----------------------------------------------------------------
   a_pn_alnum: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && overlay_on && chk_in_pn |=> (rd_data_q == FIAO_PN_FILL
      || rd_data_q inside {[8'h30:8'h39], [8'h41:8'h5a], [8'h61:8'h7a]}))
      else $error("part number byte not alphanumeric or fill");

   a_pn_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_req && overlay_on && chk_in_span && area_idx == FIAO_PN_FIRST
      |=> rd_data_q != FIAO_PN_FILL)
      else $error("part number not left-justified");

   // ----------------------------------------------------------------
   // Write blocking checks
   // ----------------------------------------------------------------
   a_write_pass: assert property (@(posedge clk_sys) disable iff (!reset_n)
      prog_wr && !(overlay_on && chk_in_span) |-> prog_wr_ok)
      else $error("write outside overlay was blocked");

   a_write_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !prog_wr |-> !prog_wr_ok)
      else $error("write pass without request");
endmodule : fiao_overlay

/* File: design/fiao_pkg.sv */
// Constants shared by the information-area overlay and its storage.
// Assumes a 16-bit program address and 8-bit program data.
package fiao_pkg;
   localparam int FIAO_ADDR_W = 16;
   localparam int FIAO_DATA_W = 8;
   localparam int FIAO_AREA_BYTES = 128;
   localparam int FIAO_IDX_W = 7;
   localparam logic [15:0] FIAO_WIN_FIRST = 16'hfe00;
   localparam logic [15:0] FIAO_WIN_LAST = 16'hfe7f;
   localparam logic [8:0] FIAO_WIN_TAG = 9'h1fc;
   localparam int FIAO_SEL_BIT = 7;
   localparam logic [7:0] FIAO_PAGE_SEL_RESET = 8'h00;
   localparam logic [6:0] FIAO_PN_FIRST = 7'h40;
   localparam logic [6:0] FIAO_PN_LAST = 7'h53;
   localparam int FIAO_PN_CHARS = 20;
   localparam logic [7:0] FIAO_PN_FILL = 8'h0f;
   localparam logic [7:0] FIAO_RESERVED_FILL = 8'hff;
   localparam logic [7:0] FIAO_RD_RESET = 8'h00;
endpackage : fiao_pkg

/* File: tb/fiao_overlay_tb.sv */
// Self-checking bench for the information-area overlay.
// Assumes the default part number and option bytes of the storage table.
`timescale 1ns/1ns
module fiao_overlay_tb;
   import fiao_pkg::*;
   logic clk_sys = 0, reset_n = 0, page_sel_wr = 0, rd_req = 0, prog_wr = 0;
   logic [7:0] page_sel_wdata = 8'h00;
   logic [15:0] rd_addr = 16'h0000;
   logic [7:0] pmem_rdata, page_sel_q, rd_data_q;
   logic rd_valid_q, prog_wr_ok;
   int n_fail = 0, n_checks = 0;
   always #50 clk_sys = ~clk_sys;
   fiao_pmem_model PM (.rd_addr(rd_addr), .pmem_rdata(pmem_rdata));
   fiao_overlay DUT (.clk_sys(clk_sys), .reset_n(reset_n), .page_sel_wr(page_sel_wr),
      .page_sel_wdata(page_sel_wdata), .page_sel_q(page_sel_q), .rd_req(rd_req),
      .rd_addr(rd_addr), .pmem_rdata(pmem_rdata), .prog_wr(prog_wr),
      .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .prog_wr_ok(prog_wr_ok));
   function automatic logic [7:0] pm(input logic [15:0] a);
      return a[7:0] ^ 8'h5a;
   endfunction : pm
   task check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task rd(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      rd_req = 1;
      rd_addr = a;
      @(negedge clk_sys);
      rd_req = 0;
      check({7'h00, rd_valid_q}, 8'h01);
      check(rd_data_q, exp);
   endtask : rd
   task sel(input logic [7:0] v);
      @(negedge clk_sys);
      page_sel_wr = 1;
      page_sel_wdata = v;
      @(negedge clk_sys);
      page_sel_wr = 0;
      check(page_sel_q, v);
   endtask : sel
   // A blocked program request must also leave the area unchanged.
   task wr_ok(input logic [15:0] a, input logic exp);
      @(negedge clk_sys);
      prog_wr = 1;
      rd_addr = a;
      #10 check({7'h00, prog_wr_ok}, {7'h00, exp});
      @(negedge clk_sys);
      prog_wr = 0;
   endtask : wr_ok
   task t_on;
      sel(8'h80);
      rd(16'hfe40, 8'h50);
      rd(16'hfe47, 8'h31);
      rd(16'hfe48, FIAO_PN_FILL);
      rd(16'hfe53, FIAO_PN_FILL);
      rd(16'hfe00, 8'hff);
      rd(16'hfe7f, 8'hff);
      rd(16'hfe80, pm(16'hfe80));
      rd(16'hfdff, pm(16'hfdff));
      wr_ok(16'hfe41, 1'b0);
      wr_ok(16'hfe80, 1'b1);
      rd(16'hfe41, 8'h41);
      wr_ok(16'hfe40, 1'b0);
      rd(16'hfe40, 8'h50);
   endtask : t_on
   task t_off;
      rd(16'hfe40, pm(16'hfe40));
      wr_ok(16'hfe41, 1'b1);
      sel(8'h7f);
      rd(16'hfe53, pm(16'hfe53));
   endtask : t_off
   task t_reset;
      check(page_sel_q, FIAO_PAGE_SEL_RESET);
      check(rd_data_q, FIAO_RD_RESET);
      check({7'h00, rd_valid_q}, 8'h00);
   endtask : t_reset
   task t_clear;
      sel(8'h00);
      rd(16'hfe40, pm(16'hfe40));
   endtask : t_clear
   task test_done;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (10) @(negedge clk_sys);
      reset_n = 1;
      t_reset;
      t_off;
      t_on;
      t_clear;
      test_done;
   end
   initial begin
      #100000;
      n_fail++;
      test_done;
   end
endmodule : fiao_overlay_tb

/* File: tb/fiao_pmem_model.sv */
// Program memory stand-in for the overlay.
// Assumes the data is wanted in the same cycle as the address.
`timescale 1ns/1ns
module fiao_pmem_model (
   input wire logic [15:0] rd_addr,
   output logic [7:0] pmem_rdata
);
   assign pmem_rdata = rd_addr[7:0] ^ 8'h5a;
endmodule : fiao_pmem_model
